// ### common/timer_consts.vh
// How it works
// - Soft one-shot trigger always reads zero
// - Soft trigger clears and restarts the counter
// - Select bit picks successive or one-shot pulses
// - Bit 4 enables inversion on compare B
// - Bit 1 enables inversion on compare A
// - Level set/reset pair forces output level
// - Level triggers read zero, clearing does nothing
// - Output enable low holds timer output low
// - Bits 7:6 pick pin B valid edge
// - Bits 5:4 pick pin A valid edge
// - Low prescaler bits select the count clock
// - High pin at first start reads rising
// - Direction bits: zero output, one input; FFh
// - Match-clear mode clears counter, raises match A
// - Interval is compare A plus one periods
// - Match B still raised in interval mode
// - Mode field: stop, free, edge-clear, match-clear
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// Register indices; byte address is four times the index
`define ADDR_W          18
`define IDX_W           16
`define IDX_PORT0_DIR   16'hFF20
`define IDX_MODE_CTRL   16'hFF86
`define IDX_PRESCALER   16'hFF87
`define IDX_OUT_CTRL    16'hFF89
`define IDX_COMPARE_A   16'hFF90
`define IDX_COMPARE_B   16'hFF91
`define IDX_COUNTER     16'hFF92

// Reset values
`define RST_PORT0_DIR   8'hFF
`define RST_PRESCALER   8'h00
`define RST_OUT_CTRL    8'h00
`define RST_OP_MODE     2'h0
`define RST_COMPARE     16'h0000

// Output control fields
`define OC_OUT_EN       0
`define OC_INV_A        1
`define OC_LVL_RESET    2
`define OC_LVL_SET      3
`define OC_INV_B        4
`define OC_OS_SEL       5
`define OC_OS_TRIG      6
`define OC_STORED_MASK  8'h33

// Prescaler/edge fields
`define PS_CLK_LO       0
`define PS_CLK_HI       1
`define PS_EDGE_A_LO    4
`define PS_EDGE_A_HI    5
`define PS_EDGE_B_LO    6
`define PS_EDGE_B_HI    7
`define PS_WRITE_MASK   8'hF3

// Mode control field
`define MC_OP_LO        2
`define MC_OP_HI        3

// Port direction bits
`define DIR_PIN0        0
`define DIR_PIN1        1

// Operation modes
`define OP_STOP         2'h0
`define OP_FREE         2'h1
`define OP_EDGE_CLR     2'h2
`define OP_MATCH_CLR    2'h3

// Count clock sources
`define CLK_FULL        2'h0
`define CLK_DIV         2'h1
`define CLK_OTHER       2'h2
`define CLK_EDGE        2'h3

// Valid edge codes
`define EDGE_FALL       2'h0
`define EDGE_RISE       2'h1
`define EDGE_BOTH       2'h3

// Prescaler divide exponent
`define PRESC_LOG2      8

// Bus responses
`define RESP_OKAY       2'h0
`define RESP_SLVERR     2'h2

`endif

// ### src/count_clock_sel.v
`timescale 1ns/1ps
`include "timer_consts.vh"

module count_clock_sel #(
	parameter DIV_LOG2 = `PRESC_LOG2
) (
	// Clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// Control
	input  wire       run,
	input  wire [1:0] sel,
	// Tick sources
	input  wire       other_irq,
	input  wire       edge_a,
	// Count enable
	output reg        tick_q
);

	reg  [DIV_LOG2-1:0] div_q;

	// Divider restarts with each start so the first period is whole
	always @(posedge aclk) begin
		if (!aresetn) begin
			div_q  <= {DIV_LOG2{1'b0}};
			tick_q <= 1'b0;
		end else begin
			if (!run) begin
				div_q <= {DIV_LOG2{1'b0}};
			end else begin
				div_q <= div_q + 1'b1;
			end
			case (sel)
				`CLK_FULL:  tick_q <= run;
				`CLK_DIV:   tick_q <= run & (&div_q);
				`CLK_OTHER: tick_q <= run & other_irq;
				`CLK_EDGE:  tick_q <= run & edge_a;
				default:    tick_q <= 1'b0;
			endcase
		end
	end

endmodule

// ### src/pin_edge_detect.v
`timescale 1ns/1ps
`include "timer_consts.vh"

module pin_edge_detect (
	// Clock and reset
	input  wire       aclk,
	input  wire       aresetn,
	// Control
	input  wire       run,
	input  wire [1:0] sel,
	// Pin and result
	input  wire       pin,
	output reg        edge_q
);

	reg  samp_q;
	reg  lvl_q;
	reg  ran_q;
	wire steady;
	wire rise;
	wire fall;

	// Two equal samples in a row count as a level; filters short glitches
	assign steady = (pin == samp_q);
	assign rise   = run & steady & pin & ~lvl_q;
	assign fall   = run & steady & ~pin & lvl_q;

	// Level held low until first start so a high pin then reads as rising
	always @(posedge aclk) begin
		if (!aresetn) begin
			samp_q <= 1'b0;
			lvl_q  <= 1'b0;
			ran_q  <= 1'b0;
			edge_q <= 1'b0;
		end else begin
			samp_q <= pin;
			ran_q  <= ran_q | run;
			if (!run && !ran_q) begin
				lvl_q <= 1'b0;
			end else if (steady) begin
				lvl_q <= pin;
			end
			case (sel)
				`EDGE_FALL: edge_q <= fall;
				`EDGE_RISE: edge_q <= rise;
				`EDGE_BOTH: edge_q <= rise | fall;
				default:    edge_q <= 1'b0;
			endcase
		end
	end

endmodule

// ### src/timer_top.v
`timescale 1ns/1ps
`include "timer_consts.vh"

module timer_top #(
	parameter DIV_LOG2 = `PRESC_LOG2
) (
	// Clock and reset
	input  wire                aclk,
	input  wire                aresetn,
	// Write address channel
	input  wire [`ADDR_W-1:0]  awaddr,
	input  wire                awvalid,
	output wire                awready,
	// Write data channel
	input  wire [31:0]         wdata,
	input  wire [3:0]          wstrb,
	input  wire                wvalid,
	output wire                wready,
	// Write response channel
	output reg  [1:0]          bresp,
	output reg                 bvalid,
	input  wire                bready,
	// Read address channel
	input  wire [`ADDR_W-1:0]  araddr,
	input  wire                arvalid,
	output wire                arready,
	// Read data channel
	output reg  [31:0]         rdata,
	output reg  [1:0]          rresp,
	output reg                 rvalid,
	input  wire                rready,
	// Pins
	input  wire                event_in_a,
	input  wire                event_in_b,
	output reg                 timer_out_pin,
	output wire                timer_out_oe,
	// Events
	input  wire                other_timer_irq,
	output reg                 match_irq_a,
	output reg                 match_irq_b,
	output wire                edge_pulse_a,
	output wire                edge_pulse_b
);

	localparam [2:0] SEL_NONE = 3'h0;
	localparam [2:0] SEL_DIR  = 3'h1;
	localparam [2:0] SEL_PRE  = 3'h2;
	localparam [2:0] SEL_OC   = 3'h3;
	localparam [2:0] SEL_MODE = 3'h4;
	localparam [2:0] SEL_CMPA = 3'h5;
	localparam [2:0] SEL_CMPB = 3'h6;
	localparam [2:0] SEL_CNT  = 3'h7;

	// Register select from a byte address
	function [2:0] reg_sel;
		input [`ADDR_W-1:0] a;
		begin
			case (a[`ADDR_W-1:2])
				`IDX_PORT0_DIR: reg_sel = SEL_DIR;
				`IDX_PRESCALER: reg_sel = SEL_PRE;
				`IDX_OUT_CTRL:  reg_sel = SEL_OC;
				`IDX_MODE_CTRL: reg_sel = SEL_MODE;
				`IDX_COMPARE_A: reg_sel = SEL_CMPA;
				`IDX_COMPARE_B: reg_sel = SEL_CMPB;
				`IDX_COUNTER:   reg_sel = SEL_CNT;
				default:        reg_sel = SEL_NONE;
			endcase
		end
	endfunction

	reg  [`ADDR_W-1:0] awaddr_q;
	reg  [31:0]        wdata_q;
	reg  [3:0]         wstrb_q;
	reg                aw_got_q;
	reg                w_got_q;
	reg  [7:0]         dir_q;
	reg  [7:0]         pre_q;
	reg  [7:0]         oc_q;
	reg  [1:0]         op_q;
	reg  [15:0]        cmpa_q;
	reg  [15:0]        cmpb_q;
	reg  [15:0]        cnt_q;
	reg  [15:0]        cnt_d;
	reg                out_q;
	reg                out_d;
	reg                armed_q;
	reg                os_trig_q;
	reg                lvl_set_q;
	reg                lvl_rst_q;
	reg  [31:0]        rd_d;
	wire [2:0]         wsel;
	wire [2:0]         rsel;
	wire               wr_fire;
	wire               wr_lo;
	wire               run;
	wire               tick;
	wire               edge_a;
	wire               edge_b;
	wire               match_a;
	wire               match_b;
	wire               fire_ok;
	wire               toggle;

	// Channel handshakes; address and data taken in either order
	assign awready = ~aw_got_q & ~bvalid;
	assign wready  = ~w_got_q & ~bvalid;
	assign arready = ~rvalid;
	assign wr_fire = aw_got_q & w_got_q;
	assign wsel    = reg_sel(awaddr_q);
	assign rsel    = reg_sel(araddr);
	assign wr_lo   = wr_fire & wstrb_q[0];

	// Write path
	always @(posedge aclk) begin
		if (!aresetn) begin
			awaddr_q <= {`ADDR_W{1'b0}};
			wdata_q  <= 32'h00000000;
			wstrb_q  <= 4'h0;
			aw_got_q <= 1'b0;
			w_got_q  <= 1'b0;
			bvalid   <= 1'b0;
			bresp    <= `RESP_OKAY;
		end else begin
			if (awvalid && awready) begin
				awaddr_q <= awaddr;
				aw_got_q <= 1'b1;
			end
			if (wvalid && wready) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
				w_got_q <= 1'b1;
			end
			if (wr_fire) begin
				aw_got_q <= 1'b0;
				w_got_q  <= 1'b0;
				bvalid   <= 1'b1;
				bresp    <= (wsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
			end else if (bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	// Software registers; trigger bits live one cycle only
	always @(posedge aclk) begin
		if (!aresetn) begin
			dir_q     <= `RST_PORT0_DIR;
			pre_q     <= `RST_PRESCALER;
			oc_q      <= `RST_OUT_CTRL;
			op_q      <= `RST_OP_MODE;
			cmpa_q    <= `RST_COMPARE;
			cmpb_q    <= `RST_COMPARE;
			os_trig_q <= 1'b0;
			lvl_set_q <= 1'b0;
			lvl_rst_q <= 1'b0;
		end else begin
			os_trig_q <= wr_lo && wsel == SEL_OC && wdata_q[`OC_OS_TRIG];
			lvl_set_q <= wr_lo && wsel == SEL_OC && wdata_q[`OC_LVL_SET];
			lvl_rst_q <= wr_lo && wsel == SEL_OC && wdata_q[`OC_LVL_RESET];
			if (wr_lo && wsel == SEL_DIR) begin
				dir_q <= wdata_q[7:0];
			end
			if (wr_lo && wsel == SEL_PRE) begin
				pre_q <= wdata_q[7:0] & `PS_WRITE_MASK;
			end
			if (wr_lo && wsel == SEL_OC) begin
				oc_q <= wdata_q[7:0] & `OC_STORED_MASK;
			end
			if (wr_lo && wsel == SEL_MODE) begin
				op_q <= wdata_q[`MC_OP_HI:`MC_OP_LO];
			end
			if (wr_fire && wsel == SEL_CMPA) begin
				if (wstrb_q[0]) cmpa_q[7:0] <= wdata_q[7:0];
				if (wstrb_q[1]) cmpa_q[15:8] <= wdata_q[15:8];
			end
			if (wr_fire && wsel == SEL_CMPB) begin
				if (wstrb_q[0]) cmpb_q[7:0] <= wdata_q[7:0];
				if (wstrb_q[1]) cmpb_q[15:8] <= wdata_q[15:8];
			end
		end
	end

	// Read mux; trigger bits never stored so they read as zero
	always @* begin
		case (rsel)
			SEL_DIR:  rd_d = {24'h000000, dir_q};
			SEL_PRE:  rd_d = {24'h000000, pre_q};
			SEL_OC:   rd_d = {24'h000000, oc_q};
			SEL_MODE: rd_d = {28'h0000000, op_q, 2'h0};
			SEL_CMPA: rd_d = {16'h0000, cmpa_q};
			SEL_CMPB: rd_d = {16'h0000, cmpb_q};
			SEL_CNT:  rd_d = {16'h0000, cnt_q};
			default:  rd_d = 32'h00000000;
		endcase
	end

	// Read path
	always @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h00000000;
			rresp  <= `RESP_OKAY;
		end else if (arvalid && arready) begin
			rvalid <= 1'b1;
			rdata  <= rd_d;
			rresp  <= (rsel == SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	assign run = (op_q != `OP_STOP);

	// Pin edge filters
	pin_edge_detect u_edge_a (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (run),
		.sel     (pre_q[`PS_EDGE_A_HI:`PS_EDGE_A_LO]),
		.pin     (event_in_a),
		.edge_q  (edge_a)
	);

	pin_edge_detect u_edge_b (
		.aclk    (aclk),
		.aresetn (aresetn),
		.run     (run),
		.sel     (pre_q[`PS_EDGE_B_HI:`PS_EDGE_B_LO]),
		.pin     (event_in_b),
		.edge_q  (edge_b)
	);

	assign edge_pulse_a = edge_a;
	assign edge_pulse_b = edge_b;

	// Count clock source
	count_clock_sel #(
		.DIV_LOG2 (DIV_LOG2)
	) u_clk_sel (
		.aclk      (aclk),
		.aresetn   (aresetn),
		.run       (run),
		.sel       (pre_q[`PS_CLK_HI:`PS_CLK_LO]),
		.other_irq (other_timer_irq),
		.edge_a    (edge_a),
		.tick_q    (tick)
	);

	// Matches are seen on the count tick at which the value stands
	assign match_a = tick & (cnt_q == cmpa_q);
	assign match_b = tick & (cnt_q == cmpb_q);
	assign fire_ok = ~oc_q[`OC_OS_SEL] | armed_q;
	assign toggle  = fire_ok & ((match_a & oc_q[`OC_INV_A]) | (match_b & oc_q[`OC_INV_B]));

	// Counter next value
	always @* begin
		if (!run) begin
			cnt_d = 16'h0000;
		end else if (os_trig_q) begin
			cnt_d = 16'h0000;
		end else if (op_q == `OP_EDGE_CLR && edge_a) begin
			cnt_d = 16'h0000;
		end else if (tick && op_q == `OP_MATCH_CLR && match_a) begin
			cnt_d = 16'h0000;
		end else if (tick) begin
			cnt_d = cnt_q + 16'h0001;
		end else begin
			cnt_d = cnt_q;
		end
	end

	// Output level: a lone set or reset trigger wins over a toggle in the same cycle; set and reset together are ignored
	always @* begin
		if (lvl_set_q && !lvl_rst_q) begin
			out_d = 1'b1;
		end else if (lvl_rst_q && !lvl_set_q) begin
			out_d = 1'b0;
		end else if (toggle) begin
			out_d = ~out_q;
		end else begin
			out_d = out_q;
		end
	end

	// Counter, output flop, one-shot arming and match events
	always @(posedge aclk) begin
		if (!aresetn) begin
			cnt_q         <= 16'h0000;
			out_q         <= 1'b0;
			armed_q       <= 1'b0;
			match_irq_a   <= 1'b0;
			match_irq_b   <= 1'b0;
			timer_out_pin <= 1'b0;
		end else begin
			cnt_q       <= cnt_d;
			out_q       <= out_d;
			match_irq_a <= match_a;
			match_irq_b <= match_b;
			// One pulse per trigger; match B ends the pulse
			if (!run) begin
				armed_q <= 1'b0;
			end else if (os_trig_q || (op_q == `OP_EDGE_CLR && edge_a)) begin
				armed_q <= 1'b1;
			end else if (match_b) begin
				armed_q <= 1'b0;
			end
			timer_out_pin <= oc_q[`OC_OUT_EN] & out_q;
		end
	end

	// Pin driver on while its direction bit selects output
	assign timer_out_oe = ~dir_q[`DIR_PIN1];

endmodule

// ### verif/event_pins_model.sv
`timescale 1ns/1ps

module event_pins_model (
	// Clock
	input  wire logic aclk,
	// Toggle requests
	input  wire logic req_a,
	input  wire logic req_b,
	// Pins
	output logic      event_in_a,
	output logic      event_in_b
);
	logic [1:0] hold_q = 2'h0;

	initial begin
		event_in_a = 1'h0;
		event_in_b = 1'h0;
	end

	// Each level held four clocks so two samples always see it
	always @(posedge aclk) begin
		if (hold_q != 2'h0) begin
			hold_q <= hold_q - 2'h1;
		end else if (req_a || req_b) begin
			event_in_a <= event_in_a ^ req_a;
			event_in_b <= event_in_b ^ req_b;
			hold_q     <= 2'h3;
		end
	end
endmodule

// ### verif/timer_checker_asserts.sv
`timescale 1ns/1ps
`include "timer_consts.vh"

module timer_checker #(
	parameter DIV_LOG2 = `PRESC_LOG2
) (
	// Clock and reset
	input wire                aclk,
	input wire                aresetn,
	// Bus
	input wire [`ADDR_W-1:0]  awaddr,
	input wire                awvalid,
	input wire                awready,
	input wire [31:0]         wdata,
	input wire                wvalid,
	input wire                wready,
	input wire [`ADDR_W-1:0]  araddr,
	input wire                arvalid,
	input wire                arready,
	input wire [31:0]         rdata,
	input wire                rvalid,
	// Timer
	input wire                timer_out_pin,
	input wire                match_irq_a,
	input wire                match_irq_b
);
	logic [7:0]  oc_q;
	logic [1:0]  mode_q;
	logic [1:0]  src_q;
	logic [15:0] cmp_a_q;
	logic [15:0] cmp_b_q;
	logic [15:0] gap_q;
	logic        seen_q;
	logic        rd_oc_q;
	wire         wr = awvalid && awready && wvalid && wready;
	wire [15:0]  wi = awaddr[`ADDR_W-1:2];

	// Shadow of software setup; assumes AW and W are taken together
	always @(posedge aclk) begin
		if (!aresetn) begin
			oc_q    <= 8'h00;
			mode_q  <= 2'h0;
			src_q   <= 2'h0;
			cmp_a_q <= 16'h0000;
			cmp_b_q <= 16'h0000;
			gap_q   <= 16'h0000;
			seen_q  <= 1'h0;
			rd_oc_q <= 1'h0;
		end else begin
			if (wr && wi == `IDX_OUT_CTRL) oc_q <= wdata[7:0];
			if (wr && wi == `IDX_PRESCALER) src_q <= wdata[1:0];
			if (wr && wi == `IDX_COMPARE_A) cmp_a_q <= wdata[15:0];
			if (wr && wi == `IDX_COMPARE_B) cmp_b_q <= wdata[15:0];
			if (wr && wi == `IDX_MODE_CTRL) mode_q <= wdata[3:2];
			gap_q  <= match_irq_a ? 16'h0000 : gap_q + 16'h0001;
			seen_q <= (wr && wi == `IDX_MODE_CTRL) ? 1'h0 : (seen_q || match_irq_a);
			if (arvalid && arready) rd_oc_q <= (araddr[`ADDR_W-1:2] == `IDX_OUT_CTRL);
		end
	end

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_set_write;
		wr && wi == `IDX_OUT_CTRL && wdata[3:2] == 2'h2 && wdata[0] && oc_q[0] && mode_q == 2'h0;
	endsequence
	sequence s_pin_high;
		##[3:4] timer_out_pin;
	endsequence
	property p_level_set;
		s_set_write |-> s_pin_high;
	endproperty
	a_level_set: assert property (p_level_set)
		else $error("output not high after level set");
	property p_out_low;
		!oc_q[0] [*3] |-> !timer_out_pin;
	endproperty
	a_out_low: assert property (p_out_low)
		else $error("output high while disabled");
	property p_rst;
		@(posedge aclk) disable iff (1'b0) !aresetn |=> !timer_out_pin && !match_irq_a && !match_irq_b;
	endproperty
	a_rst: assert property (p_rst)
		else $error("outputs not cleared by reset");
	property p_irq_pulse;
		match_irq_a |=> !match_irq_a;
	endproperty
	a_irq_pulse: assert property (p_irq_pulse)
		else $error("match a longer than one cycle");
	property p_interval;
		match_irq_a && seen_q && mode_q == 2'h3 && src_q == 2'h0 |-> gap_q == cmp_a_q;
	endproperty
	a_interval: assert property (p_interval)
		else $error("interval not compare plus one");
	property p_irq_b;
		match_irq_a && mode_q == 2'h3 && src_q == 2'h0 && cmp_b_q <= cmp_a_q && cmp_a_q < 16'h00C8
			|-> ##[0:201] (match_irq_b || mode_q != 2'h3);
	endproperty
	a_irq_b: assert property (p_irq_b)
		else $error("match b missing in interval mode");
	property p_toggle;
		match_irq_a && seen_q && mode_q == 2'h3 && oc_q[5:0] == 6'h13 |-> ##[0:2] $changed(timer_out_pin);
	endproperty
	a_toggle: assert property (p_toggle)
		else $error("output did not toggle on match a");
	property p_rd_zero;
		rvalid && rd_oc_q |-> rdata[6] == 1'h0 && rdata[3:2] == 2'h0;
	endproperty
	a_rd_zero: assert property (p_rd_zero)
		else $error("trigger bits read nonzero");
endmodule

bind timer_top timer_checker #(.DIV_LOG2(DIV_LOG2)) checker_i (
	.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
	.wdata(wdata), .wvalid(wvalid), .wready(wready), .araddr(araddr), .arvalid(arvalid),
	.arready(arready), .rdata(rdata), .rvalid(rvalid), .timer_out_pin(timer_out_pin),
	.match_irq_a(match_irq_a), .match_irq_b(match_irq_b)
);

// ### verif/timer_output_prescaler_interval_bench.sv
`timescale 1ns/1ps
`include "timer_consts.vh"

module timer_output_prescaler_interval_bench;
	typedef struct packed {
		logic [15:0] i;
		logic        w;
		logic [7:0]  d;
		logic [7:0]  e;
		logic [1:0]  r;
	} row_t;
	logic               aclk = 1'h0;
	logic               aresetn = 1'h0;
	logic [`ADDR_W-1:0] awaddr = '0;
	logic [`ADDR_W-1:0] araddr = '0;
	logic [31:0]        wdata = 32'h0;
	logic [3:0]         wstrb = 4'h0;
	logic               awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0;
	logic               rready = 1'h0, other_timer_irq = 1'h0, req_a = 1'h0, req_b = 1'h0;
	wire                awready, wready, bvalid, arready, rvalid, event_in_a, event_in_b;
	wire                timer_out_pin, timer_out_oe, match_irq_a, match_irq_b;
	wire                edge_pulse_a, edge_pulse_b;
	wire [1:0]          bresp, rresp;
	wire [31:0]         rdata;
	logic [31:0]        q;
	logic [1:0]         r;
	int                 mismatches = 0, n_compared = 0, cyc = 0, c, k, n, nb, na;
	row_t               rows [10];
	logic [7:0]         psel [4] = '{8'h00, 8'h01, 8'h02, 8'h33};

	always #4 aclk = ~aclk;

	// Hang guard, far above the expected run length
	always @(posedge aclk) begin
		cyc++;
		if (cyc == 20000) begin
			mismatches++;
			tally_and_finish();
		end
	end

	// Short prescaler so the divided source ticks every four clocks
	timer_top #(.DIV_LOG2(2)) dut (
		.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
		.bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready), .event_in_a(event_in_a),
		.event_in_b(event_in_b), .timer_out_pin(timer_out_pin), .timer_out_oe(timer_out_oe),
		.other_timer_irq(other_timer_irq), .match_irq_a(match_irq_a), .match_irq_b(match_irq_b),
		.edge_pulse_a(edge_pulse_a), .edge_pulse_b(edge_pulse_b)
	);
	event_pins_model pins (.aclk(aclk), .req_a(req_a), .req_b(req_b),
		.event_in_a(event_in_a), .event_in_b(event_in_b));

	task chk(input logic [31:0] g, input logic [31:0] e, input string m);
		n_compared++;
		if (g !== e) begin
			mismatches++;
			$display("ERROR %0t: %s got %h expected %h", $time, m, g, e);
		end
	endtask

	// One bus cycle; also ends any other_timer_irq or req_a stimulus pulse
	task xfer(input logic w, input logic [15:0] i, input logic [31:0] d);
		int t;
		t = 0;
		@(posedge aclk);
		awaddr <= {i, 2'h0};
		araddr <= {i, 2'h0};
		awvalid <= w;
		wvalid <= w;
		wdata <= d;
		wstrb <= 4'hF;
		bready <= w;
		arvalid <= !w;
		rready <= !w;
		other_timer_irq <= 1'h0;
		req_a <= 1'h0;
		do begin
			@(posedge aclk);
			t++;
			if (awready) awvalid <= 1'h0;
			if (wready) wvalid <= 1'h0;
			if (arready) arvalid <= 1'h0;
		end while ((w ? bvalid : rvalid) !== 1'h1 && t < 50);
		q = rdata;
		r = w ? bresp : rresp;
		bready <= 1'h0;
		rready <= 1'h0;
		if (t >= 50) chk(t, 0, "bus stall");
	endtask

	task oc_pin(input logic [7:0] d, input logic e);
		xfer(1'h1, `IDX_OUT_CTRL, {24'h0, d});
		repeat (4) @(posedge aclk);
		chk(timer_out_pin, e, "output level");
	endtask

	task tally_and_finish;
		$display("compared %0d mismatches %0d", n_compared, mismatches);
		if (mismatches == 0 && n_compared > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask

	initial begin
		rows = '{'{`IDX_PORT0_DIR, 1'h0, 8'h00, 8'hFF, `RESP_OKAY},
			'{`IDX_PRESCALER, 1'h0, 8'h00, 8'h00, `RESP_OKAY},
			'{`IDX_OUT_CTRL, 1'h0, 8'h00, 8'h00, `RESP_OKAY},
			'{`IDX_PRESCALER, 1'h1, 8'hFF, 8'hF3, `RESP_OKAY},
			'{`IDX_OUT_CTRL, 1'h1, 8'h12, 8'h12, `RESP_OKAY},
			'{`IDX_OUT_CTRL, 1'h1, 8'h13, 8'h13, `RESP_OKAY},
			'{`IDX_OUT_CTRL, 1'h1, 8'h73, 8'h33, `RESP_OKAY},
			'{`IDX_OUT_CTRL, 1'h1, 8'h13, 8'h13, `RESP_OKAY},
			'{`IDX_OUT_CTRL, 1'h1, 8'h1B, 8'h13, `RESP_OKAY},
			'{16'h0000, 1'h0, 8'h00, 8'h00, `RESP_SLVERR}};
		repeat (5) @(posedge aclk);
		aresetn <= 1'h1;
		// Register table: reset values, stored bits, write-only triggers
		foreach (rows[j]) begin
			if (rows[j].w) xfer(1'h1, rows[j].i, {24'h0, rows[j].d});
			xfer(1'h0, rows[j].i, 32'h0);
			chk({r, q[7:0]}, {rows[j].r, rows[j].e}, "readback");
		end
		chk(timer_out_pin, 1'h1, "level set");
		oc_pin(8'h17, 1'h0);
		oc_pin(8'h1B, 1'h1);
		oc_pin(8'h13, 1'h1);
		oc_pin(8'h12, 1'h0);
		xfer(1'h1, `IDX_OUT_CTRL, 32'h13);
		xfer(1'h1, `IDX_PORT0_DIR, 32'hFD);
		chk(timer_out_oe, 1'h1, "pin drive");
		xfer(1'h1, `IDX_COMPARE_A, 32'h5);
		xfer(1'h1, `IDX_COMPARE_B, 32'h2);
		// Every count source; non-full sources tick once per four clocks
		nb = 0;
		for (int s = 0; s < 4; s++) begin
			xfer(1'h1, `IDX_MODE_CTRL, 32'h0);
			xfer(1'h1, `IDX_PRESCALER, {24'h0, psel[s]});
			xfer(1'h1, `IDX_MODE_CTRL, 32'hC);
			n = 0;
			k = 0;
			c = 0;
			while (n < 2 && c < 400) begin
				@(posedge aclk);
				c++;
				other_timer_irq <= (s == 2 && c % 4 == 0);
				req_a <= (s == 3 && c % 4 == 0);
				nb += (match_irq_b === 1'h1);
				if (match_irq_a === 1'h1) begin
					n++;
					if (n == 1) k = c;
				end
			end
			chk(c - k, s ? 24 : 6, "interval");
		end
		chk(nb > 0, 1'h1, "match b");
		xfer(1'h1, `IDX_MODE_CTRL, 32'h0);
		xfer(1'h0, `IDX_COUNTER, 32'h0);
		chk(q, 32'h0, "stopped count");
		// Pin B rising only, pin A both: B pulses on the rise only, A on each toggle
		xfer(1'h1, `IDX_PRESCALER, 32'h70);
		xfer(1'h1, `IDX_MODE_CTRL, 32'h4);
		for (int e = 1; e >= 0; e--) begin
			@(posedge aclk);
			req_b <= 1'h1;
			req_a <= 1'h1;
			@(posedge aclk);
			req_b <= 1'h0;
			req_a <= 1'h0;
			n = 0;
			na = 0;
			repeat (8) begin
				@(posedge aclk);
				n += (edge_pulse_b === 1'h1);
				na += (edge_pulse_a === 1'h1);
			end
			chk(n, e, "edge b");
			chk(na, 1, "edge a");
		end
		xfer(1'h1, `IDX_MODE_CTRL, 32'h0);
		// Soft trigger in free run, pin A edge in edge-clear mode: both restart the count
		xfer(1'h1, `IDX_OUT_CTRL, 32'h33);
		xfer(1'h1, `IDX_PRESCALER, 32'h30);
		for (int m = 1; m <= 2; m++) begin
			xfer(1'h1, `IDX_MODE_CTRL, (m == 1) ? 32'h4 : 32'h8);
			repeat (40) @(posedge aclk);
			xfer(1'h0, `IDX_COUNTER, 32'h0);
			chk(q > 32'h20, 1'h1, "count runs");
			if (m == 1) begin
				xfer(1'h1, `IDX_OUT_CTRL, 32'h73);
			end else begin
				@(posedge aclk);
				req_a <= 1'h1;
				@(posedge aclk);
				req_a <= 1'h0;
				repeat (4) @(posedge aclk);
			end
			xfer(1'h0, `IDX_COUNTER, 32'h0);
			chk(q < 32'h8, 1'h1, "count restart");
			xfer(1'h1, `IDX_MODE_CTRL, 32'h0);
		end
		// Reset in mid-run: pins and registers go back to their reset state
		xfer(1'h1, `IDX_MODE_CTRL, 32'h4);
		@(posedge aclk);
		aresetn <= 1'h0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'h1;
		chk({timer_out_pin, timer_out_oe}, 2'h0, "reset pins");
		xfer(1'h0, `IDX_PORT0_DIR, 32'h0);
		chk(q[7:0], `RST_PORT0_DIR, "reset direction");
		xfer(1'h0, `IDX_COUNTER, 32'h0);
		chk(q, 32'h0, "reset count");
		tally_and_finish();
	end
endmodule
